/* rtl/tsgp_regs.svh */
`ifndef TSGP_REGS_SVH
`define TSGP_REGS_SVH

// register word addresses (byte address = 4 x index)
`define TSGP_IDX_A_DATA   4'h0
`define TSGP_IDX_A_DIR    4'h1
`define TSGP_IDX_A_PULL   4'h2
`define TSGP_IDX_A_TDIS   4'h3
`define TSGP_IDX_B_DATA   4'h4
`define TSGP_IDX_B_DIR    4'h5
`define TSGP_IDX_B_PULL   4'h6
`define TSGP_IDX_B_TDIS   4'h7
`define TSGP_IDX_STBY     4'h8
`define TSGP_IDX_STATUS   4'h9

// implemented-bit masks
`define TSGP_A_PORT_MASK  8'hE8
`define TSGP_A_TDIS_MASK  8'h1E
`define TSGP_B_MASK       8'h03
`define TSGP_STBY_MASK    8'h0F

// standby control field positions
`define TSGP_STBY_PIN_BIT   0
`define TSGP_STBY_TSTOP_BIT 1
`define TSGP_STBY_TOUCH_INTERRUPT_BIT  2
`define TSGP_STBY_TOUCH_GENERAL_INTERRUPT_BIT  3

// reset values
`define TSGP_RST_BYTE     8'h00
`define TSGP_RST_WORD     32'h0000_0000

`endif

/* rtl/tsgp_pkg.sv */
package tsgp_pkg;

  // per-pin control view, six pins: a7 a6 a5 a3 b1 b0 packed high to low
  typedef struct packed {
    logic [5:0] dir;
    logic [5:0] data;
    logic [5:0] pull;
    logic [5:0] tdis;
  } tsgp_pin_cfg_t;

  // pad-side signals for the six pins
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
    logic [5:0] pull_en;
    logic [5:0] touch_en;
  } tsgp_pad_t;

endpackage : tsgp_pkg

/* rtl/tsgp_ports.sv */
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
`include "tsgp_regs.svh"

// Function
// - direction bit one means output, zero input
// - output pin driven from data latch
// - data write always updates latch
// - output pin read returns latch
// - input pin read returns synced pin
// - read-modify-write read returns latch always
// - reset clears all direction bits
// - standby with pin bit: hi-z, input blocked
// - standby without pin bit holds state
// - touch stop enable keeps touch inputs alive
// - wake needs touch and general interrupt
// - disable bit zero touch, one port input
// - pull-up bit one connects pull-up
// - pull-up dropped while driving low
// - port a bits 7,6,5,3; disable 3,2,1,4
// - port b bits 0 and 1 everywhere
module tsgp_ports (
  input  wire logic                clk,
  input  wire logic                nrst,
  // avalon-mm slave
  input  wire logic [5:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic                avs_rmw,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  // system standby request and touch controller interrupt requests
  input  wire logic                standby_req,
  input  wire logic                touch_irq,
  input  wire logic                touch_gen_irq,
  // pads, port a bits 7..0 and port b bits 1..0
  input  wire logic [7:0]          pin_a_in,
  input  wire logic [1:0]          pin_b_in,
  output logic      [7:0]          pin_a_out,
  output logic      [7:0]          pin_a_oe,
  output logic      [7:0]          pin_a_pull,
  output logic      [1:0]          pin_b_out,
  output logic      [1:0]          pin_b_oe,
  output logic      [1:0]          pin_b_pull,
  // touch path enables, channel order ref,ch1..ch5
  output logic      [5:0]          touch_path_en,
  output logic                     touch_wake
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] a_data_q, a_dir_q, a_pull_q, a_tdis_q;   // port a
  logic [7:0] b_data_q, b_dir_q, b_pull_q, b_tdis_q;   // port b
  logic [7:0] stby_q;                                   // standby control
  logic [7:0] a_s1_q, a_s2_q;                           // port a synchroniser
  logic [1:0] b_s1_q, b_s2_q;                           // port b synchroniser
  logic       stby_s1_q, stby_s2_q;                     // standby request sync
  logic       ack_q;                                    // one-cycle answer
  tsgp_pkg::tsgp_pin_cfg_t cfg;                         // per-pin view
  tsgp_pkg::tsgp_pad_t     pad;                         // pad view

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // choose latch or pin per bit for reads
  function automatic logic [7:0] port_view(input logic [7:0] latch,
                                           input logic [7:0] pins,
                                           input logic [7:0] dir,
                                           input logic       rmw);
    port_view = rmw ? latch : ((latch & dir) | (pins & ~dir));
  endfunction : port_view

  // masked write merge
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] wdat,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (wdat & mask);
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire [3:0] idx      = avs_address[5:2];
  wire       wr_go    = avs_write && !ack_q;
  wire       rd_go    = avs_read && !ack_q;
  wire [7:0] wd       = avs_writedata[7:0];
  wire       standby  = stby_s2_q;
  wire       pin_lock = standby && stby_q[`TSGP_STBY_PIN_BIT];
  wire       t_stop   = stby_q[`TSGP_STBY_TSTOP_BIT];
  // blocked pins read low while locked; the input gate is shut so that
  // a floating pad cannot leak through the synchroniser into a read
  // limitation: an output pin still reads its latch while locked, since
  // the read path follows the direction bits, not the pad state
  wire [7:0] a_pins   = pin_lock ? `TSGP_RST_BYTE : a_s2_q;
  wire [1:0] b_pins   = pin_lock ? 2'b00 : b_s2_q;

  // per-pin gather: port a pins 7,6,5,3 use disable bits 3,2,1,4
  assign cfg.dir  = {a_dir_q[7], a_dir_q[6], a_dir_q[5], a_dir_q[3],
                     b_dir_q[1], b_dir_q[0]};
  assign cfg.data = {a_data_q[7], a_data_q[6], a_data_q[5], a_data_q[3],
                     b_data_q[1], b_data_q[0]};
  assign cfg.pull = {a_pull_q[7], a_pull_q[6], a_pull_q[5], a_pull_q[3],
                     b_pull_q[1], b_pull_q[0]};
  assign cfg.tdis = {a_tdis_q[3], a_tdis_q[2], a_tdis_q[1], a_tdis_q[4],
                     b_tdis_q[1], b_tdis_q[0]};

  // pad logic; in standby without lock everything simply stays as is
  assign pad.oe       = pin_lock ? 6'b00_0000 : cfg.dir;
  assign pad.out      = cfg.data & pad.oe;
  assign pad.pull_en  = (pin_lock ? 6'b00_0000 : cfg.pull)
                        & ~(pad.oe & ~cfg.data);
  // touch path open when disable bit is zero, unless locked out
  assign pad.touch_en = ~cfg.tdis & {6{!pin_lock || t_stop}};

  // read mux
  wire [7:0] rd_mux =
    (idx == `TSGP_IDX_A_DATA) ? port_view(a_data_q, a_pins & `TSGP_A_PORT_MASK,
                                          a_dir_q, avs_rmw) :
    (idx == `TSGP_IDX_A_DIR)  ? a_dir_q  :
    (idx == `TSGP_IDX_A_PULL) ? a_pull_q :
    (idx == `TSGP_IDX_A_TDIS) ? a_tdis_q :
    (idx == `TSGP_IDX_B_DATA) ? port_view(b_data_q, {6'b00_0000, b_pins},
                                          b_dir_q, avs_rmw) :
    (idx == `TSGP_IDX_B_DIR)  ? b_dir_q  :
    (idx == `TSGP_IDX_B_PULL) ? b_pull_q :
    (idx == `TSGP_IDX_B_TDIS) ? b_tdis_q :
    (idx == `TSGP_IDX_STBY)   ? stby_q   :
    (idx == `TSGP_IDX_STATUS) ? {6'b00_0000, touch_wake, standby} :
                                `TSGP_RST_BYTE;                      // unmapped: zero

  // wake only if both interrupt paths permit it and controller runs in stop
  wire wake_d = standby && t_stop && stby_q[`TSGP_STBY_TOUCH_INTERRUPT_BIT]
                && stby_q[`TSGP_STBY_TOUCH_GENERAL_INTERRUPT_BIT] && touch_irq && touch_gen_irq;

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers: first stage read only by second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      a_s1_q    <= `TSGP_RST_BYTE;
      a_s2_q    <= `TSGP_RST_BYTE;
      b_s1_q    <= 2'b00;
      b_s2_q    <= 2'b00;
      stby_s1_q <= 1'b0;
      stby_s2_q <= 1'b0;
    end else begin
      a_s1_q    <= pin_a_in;
      a_s2_q    <= a_s1_q;
      b_s1_q    <= pin_b_in;
      b_s2_q    <= b_s1_q;
      stby_s1_q <= standby_req;
      stby_s2_q <= stby_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes; pull/disable/latch reset to zero as well
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      a_data_q <= `TSGP_RST_BYTE;
      a_dir_q  <= `TSGP_RST_BYTE;
      a_pull_q <= `TSGP_RST_BYTE;
      a_tdis_q <= `TSGP_RST_BYTE;
      b_data_q <= `TSGP_RST_BYTE;
      b_dir_q  <= `TSGP_RST_BYTE;
      b_pull_q <= `TSGP_RST_BYTE;
      b_tdis_q <= `TSGP_RST_BYTE;
      stby_q   <= `TSGP_RST_BYTE;
    end else if (wr_go) begin
      unique case (idx)
        `TSGP_IDX_A_DATA: a_data_q <= merge(a_data_q, wd, `TSGP_A_PORT_MASK);
        `TSGP_IDX_A_DIR:  a_dir_q  <= merge(a_dir_q,  wd, `TSGP_A_PORT_MASK);
        `TSGP_IDX_A_PULL: a_pull_q <= merge(a_pull_q, wd, `TSGP_A_PORT_MASK);
        `TSGP_IDX_A_TDIS: a_tdis_q <= merge(a_tdis_q, wd, `TSGP_A_TDIS_MASK);
        `TSGP_IDX_B_DATA: b_data_q <= merge(b_data_q, wd, `TSGP_B_MASK);
        `TSGP_IDX_B_DIR:  b_dir_q  <= merge(b_dir_q,  wd, `TSGP_B_MASK);
        `TSGP_IDX_B_PULL: b_pull_q <= merge(b_pull_q, wd, `TSGP_B_MASK);
        `TSGP_IDX_B_TDIS: b_tdis_q <= merge(b_tdis_q, wd, `TSGP_B_MASK);
        `TSGP_IDX_STBY:   stby_q   <= merge(stby_q,   wd, `TSGP_STBY_MASK);
        default: ;                                                    // unmapped ignored
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer: waitrequest high until the cycle after the request
  // the answer is registered so that waitrequest comes from a flop; the
  // price is one wait state per access, and ack_q blocks a second take
  // of the same request while the master has not yet released it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_q           <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= `TSGP_RST_WORD;
    end else begin
      ack_q           <= (rd_go || wr_go);
      avs_waitrequest <= !(rd_go || wr_go);
      if (rd_go) begin
        avs_readdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered pad outputs, one cycle behind the control registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_a_out     <= `TSGP_RST_BYTE;
      pin_a_oe      <= `TSGP_RST_BYTE;
      pin_a_pull    <= `TSGP_RST_BYTE;
      pin_b_out     <= 2'b00;
      pin_b_oe      <= 2'b00;
      pin_b_pull    <= 2'b00;
      touch_path_en <= 6'b00_0000;
      touch_wake    <= 1'b0;
    end else begin
      pin_a_out     <= {pad.out[5:3], 1'b0, pad.out[2], 3'b000};
      pin_a_oe      <= {pad.oe[5:3], 1'b0, pad.oe[2], 3'b000};
      pin_a_pull    <= {pad.pull_en[5:3], 1'b0, pad.pull_en[2], 3'b000};
      pin_b_out     <= pad.out[1:0];
      pin_b_oe      <= pad.oe[1:0];
      pin_b_pull    <= pad.pull_en[1:0];
      // ref, ch1, ch2, ch3, ch4, ch5
      touch_path_en <= {pad.touch_en[2], pad.touch_en[3], pad.touch_en[4],
                        pad.touch_en[5], pad.touch_en[0], pad.touch_en[1]};
      touch_wake    <= wake_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_dir_drives_oe: assert property (@(posedge clk) disable iff (!nrst)
    !pin_lock |=> pin_a_oe[7] == $past(a_dir_q[7]))
    else $error("port a oe does not follow direction");
  a_out_from_latch: assert property (@(posedge clk) disable iff (!nrst)
    pin_b_oe[0] |-> pin_b_out[0] == $past(b_data_q[0]))
    else $error("output does not follow latch");
  a_write_latch: assert property (@(posedge clk) disable iff (!nrst)
    (wr_go && idx == `TSGP_IDX_B_DATA) |=> b_data_q == (avs_writedata[7:0] & `TSGP_B_MASK))
    else $error("latch write lost");
  a_rmw_read_latch: assert property (@(posedge clk) disable iff (!nrst)
    (rd_go && avs_rmw && idx == `TSGP_IDX_A_DATA) |=> avs_readdata[7:0] == $past(a_data_q))
    else $error("rmw read not latch");
  a_input_read_pin: assert property (@(posedge clk) disable iff (!nrst)
    (rd_go && !avs_rmw && idx == `TSGP_IDX_B_DATA && b_dir_q == 8'h00)
    |=> avs_readdata[1:0] == $past(b_pins))
    else $error("input read not pin");
  a_lock_hiz: assert property (@(posedge clk) disable iff (!nrst)
    pin_lock |=> (pin_a_oe == 8'h00 && pin_b_oe == 2'b00))
    else $error("locked pin still driven");
  a_pull_low_off: assert property (@(posedge clk) disable iff (!nrst)
    (pin_a_oe[5] && !pin_a_out[5]) |-> !pin_a_pull[5])
    else $error("pull-up on while driving low");
  a_touch_disable: assert property (@(posedge clk) disable iff (!nrst)
    a_tdis_q[4] |=> !touch_path_en[5])
    else $error("reference path open while disabled");
  a_unused_zero: assert property (@(posedge clk) disable iff (!nrst)
    (b_dir_q[7:2] == 6'b00_0000) && (a_dir_q[2:0] == 3'b000))
    else $error("unimplemented bit set");
  a_bus_answer: assert property (@(posedge clk) disable iff (!nrst)
    (rd_go || wr_go) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");

  ////////////////////////////////////////////////////////////////////////////
  // further checks, one or more per rule of the device side except the reset rule
  // pad outputs lag the registers by one flop, so most checks compare
  // against the registers as they stood one cycle earlier
  // whole-port direction to output enable, both ports
  a_dir_oe_a: assert property (@(posedge clk) disable iff (!nrst)
    !pin_lock |=> pin_a_oe == $past(a_dir_q & `TSGP_A_PORT_MASK))
    else $error("port a oe does not follow direction");
  a_dir_oe_b: assert property (@(posedge clk) disable iff (!nrst)
    !pin_lock |=> pin_b_oe == $past(b_dir_q[1:0]))
    else $error("port b oe does not follow direction");
  // output level equals latch on driven pins, zero elsewhere
  a_out_a_latch: assert property (@(posedge clk) disable iff (!nrst)
    !pin_lock |=> pin_a_out == $past(a_data_q & a_dir_q & `TSGP_A_PORT_MASK))
    else $error("port a output does not follow latch");
  a_out_b_latch: assert property (@(posedge clk) disable iff (!nrst)
    !pin_lock |=> pin_b_out == $past(b_data_q[1:0] & b_dir_q[1:0]))
    else $error("port b output does not follow latch");
  // latch write lands whatever the direction
  a_write_a_latch: assert property (@(posedge clk) disable iff (!nrst)
    (wr_go && idx == `TSGP_IDX_A_DATA)
    |=> a_data_q == (avs_writedata[7:0] & `TSGP_A_PORT_MASK))
    else $error("port a latch write lost");
  // ordinary read of an all-output port returns the latch
  a_output_read_latch: assert property (@(posedge clk) disable iff (!nrst)
    (rd_go && !avs_rmw && idx == `TSGP_IDX_A_DATA && a_dir_q == `TSGP_A_PORT_MASK)
    |=> avs_readdata[7:0] == $past(a_data_q))
    else $error("output read not latch");
  // ordinary read of an all-input port returns the synced pins
  a_input_read_a: assert property (@(posedge clk) disable iff (!nrst)
    (rd_go && !avs_rmw && idx == `TSGP_IDX_A_DATA && a_dir_q == `TSGP_RST_BYTE)
    |=> avs_readdata[7:0] == $past(a_pins & `TSGP_A_PORT_MASK))
    else $error("port a input read not pin");
  // rmw read on port b returns the latch
  a_rmw_read_b: assert property (@(posedge clk) disable iff (!nrst)
    (rd_go && avs_rmw && idx == `TSGP_IDX_B_DATA)
    |=> avs_readdata[7:0] == $past(b_data_q))
    else $error("port b rmw read not latch");
  // lock drops every pull-up as well
  a_lock_pull_off: assert property (@(posedge clk) disable iff (!nrst)
    pin_lock |=> (pin_a_pull == `TSGP_RST_BYTE && pin_b_pull == 2'b00))
    else $error("pull-up on while locked");
  // locked input pins read low, output pins still the latch
  a_lock_read_low: assert property (@(posedge clk) disable iff (!nrst)
    (rd_go && !avs_rmw && pin_lock && idx == `TSGP_IDX_A_DATA)
    |=> avs_readdata[7:0] == $past(a_data_q & a_dir_q))
    else $error("locked input read not low");
  // standby without the pin bit keeps driving as before
  a_hold_no_lock: assert property (@(posedge clk) disable iff (!nrst)
    (standby && !stby_q[`TSGP_STBY_PIN_BIT])
    |=> pin_a_oe == $past(a_dir_q & `TSGP_A_PORT_MASK))
    else $error("unlocked standby changed drive");
  // touch stop enable keeps the reference path open under lock
  a_touch_stop_open: assert property (@(posedge clk) disable iff (!nrst)
    (pin_lock && t_stop && !a_tdis_q[4]) |=> touch_path_en[5])
    else $error("touch path blocked with stop enable");
  // without it the lock closes every touch path
  a_lock_touch_shut: assert property (@(posedge clk) disable iff (!nrst)
    (pin_lock && !t_stop) |=> touch_path_en == 6'b00_0000)
    else $error("touch path open while locked");
  // wake only with both interrupts and both enables
  a_wake_both_irq: assert property (@(posedge clk) disable iff (!nrst)
    touch_wake |-> $past(touch_irq && touch_gen_irq))
    else $error("wake without both interrupts");
  a_wake_enables: assert property (@(posedge clk) disable iff (!nrst)
    touch_wake |-> $past(stby_q[`TSGP_STBY_TOUCH_INTERRUPT_BIT] && stby_q[`TSGP_STBY_TOUCH_GENERAL_INTERRUPT_BIT]))
    else $error("wake without both enables");
  // disable bit zero opens the channel four path on port b
  a_touch_open_b: assert property (@(posedge clk) disable iff (!nrst)
    (!pin_lock && !b_tdis_q[0]) |=> touch_path_en[1])
    else $error("touch path closed while enabled");
  // pull bit on an input pin connects the pull-up
  a_pull_connect: assert property (@(posedge clk) disable iff (!nrst)
    (!pin_lock && a_pull_q[7] && !a_dir_q[7]) |=> pin_a_pull[7])
    else $error("pull-up not connected");
  a_pull_low_b: assert property (@(posedge clk) disable iff (!nrst)
    (pin_b_oe[0] && !pin_b_out[0]) |-> !pin_b_pull[0])
    else $error("port b pull-up on while driving low");
  // only the implemented bits can ever hold a one
  a_unused_a_zero: assert property (@(posedge clk) disable iff (!nrst)
    ((a_data_q & ~`TSGP_A_PORT_MASK) == `TSGP_RST_BYTE)
    && ((a_tdis_q & ~`TSGP_A_TDIS_MASK) == `TSGP_RST_BYTE))
    else $error("port a unimplemented bit set");
  a_unused_b_zero: assert property (@(posedge clk) disable iff (!nrst)
    (b_data_q[7:2] == 6'b00_0000) && (b_pull_q[7:2] == 6'b00_0000)
    && (b_tdis_q[7:2] == 6'b00_0000))
    else $error("port b unimplemented bit set");
  // unmapped indices answer zero
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!nrst)
    (rd_go && idx > `TSGP_IDX_STATUS) |=> avs_readdata == `TSGP_RST_WORD)
    else $error("unmapped read not zero");

  c_rmw_read:   cover property (@(posedge clk) disable iff (!nrst) rd_go && avs_rmw);
  c_lock_entry: cover property (@(posedge clk) disable iff (!nrst) $rose(pin_lock));
  c_wake:       cover property (@(posedge clk) disable iff (!nrst) touch_wake);
  c_drive_low:  cover property (@(posedge clk) disable iff (!nrst) pin_a_oe[7] && !pin_a_out[7]);
  c_touch_stop: cover property (@(posedge clk) disable iff (!nrst) pin_lock && t_stop);

endmodule : tsgp_ports

/* verif/tsgp_pad_model.sv */
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////
// pads outside the block: block drive, else bench drive, else pull-up, else floating
module tsgp_pad_model (
  input  wire logic       clk,
  input  wire logic [9:0] pad_out,   // {a, b} levels driven by block
  input  wire logic [9:0] pad_oe,    // high while block drives
  input  wire logic [9:0] pad_pull,  // internal pull-up connected
  input  wire logic [9:0] ext_val,   // level forced by outside world
  input  wire logic [9:0] ext_en,    // outside world drives the pin
  output logic      [9:0] pad_in     // level seen back at the block
);
  logic [9:0] float_q = 10'h155;  // open pins wander, never a stable guess
  // flip every cycle so a stale value cannot pass for a read
  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end
  // block drive wins, then outside drive, then pull-up, then float
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                | (~pad_oe & ~ext_en & pad_pull) | (~pad_oe & ~ext_en & ~pad_pull & float_q);
endmodule : tsgp_pad_model

/* verif/tb_top.sv */
`timescale 1ns/100ps
`include "tsgp_regs.svh"
module tb_top;
  logic        clk = 0, nrst = 0, avs_read = 0, avs_write = 0, avs_rmw = 0;
  logic [5:0]  avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, d;
  logic        avs_waitrequest, standby_req = 0, touch_irq = 0, touch_gen_irq = 0;
  logic [7:0]  pin_a_out, pin_a_oe, pin_a_pull, pin_a_in;
  logic [1:0]  pin_b_out, pin_b_oe, pin_b_pull, pin_b_in;
  logic [5:0]  touch_path_en;
  logic        touch_wake;
  logic [9:0]  ext_val = 10'h000, ext_en = 10'h3FF;  // outside drive
  int          miscompares = 0, checks = 0;
  tsgp_ports i_dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_rmw(avs_rmw),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .standby_req(standby_req), .touch_irq(touch_irq), .touch_gen_irq(touch_gen_irq),
    .pin_a_in(pin_a_in), .pin_b_in(pin_b_in), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
    .pin_a_pull(pin_a_pull), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe),
    .pin_b_pull(pin_b_pull), .touch_path_en(touch_path_en), .touch_wake(touch_wake));
  tsgp_pad_model i_pads (.clk(clk), .pad_out({pin_a_out, pin_b_out}),
    .pad_oe({pin_a_oe, pin_b_oe}), .pad_pull({pin_a_pull, pin_b_pull}),
    .ext_val(ext_val), .ext_en(ext_en), .pad_in({pin_a_in, pin_b_in}));
  //////////////////////////////////////////////////////////////////////
  always #10 clk = ~clk;  // 50 mhz
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  // compare one value, report at once
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one avalon cycle; request held until waitrequest seen low
  task automatic bus(input logic [3:0] idx, input logic wr, input logic rmw,
                     input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h00_0000, v};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_rmw <= rmw;
    do @(posedge clk); while (avs_waitrequest !== 1'b0 && n++ < 20);
    if (n >= 20) chk("waitrequest", 32'h0000_0000, 32'h0000_0001);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    avs_rmw <= 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] idx, input logic rmw, input logic [7:0] e);
    bus(idx, 1'b0, rmw, 8'h00);
    chk("readdata", {24'h00_0000, e}, d);
  endtask : rd
  task automatic settle;
    repeat (4) @(posedge clk);  // two sync flops plus pad register
  endtask : settle
  //////////////////////////////////////////////////////////////////////
  // reset values, status and an unmapped index all read zero
  task automatic t_reset;
    for (int i = 0; i < 11; i++) rd(i[3:0], 1'b0, 8'h00);
    chk("a_oe", 32'h0000_0000, {24'h00_0000, pin_a_oe});
  endtask : t_reset
  // latch written while input stays off the pin, then appears as output
  task automatic t_out;
    bus(`TSGP_IDX_A_DATA, 1'b1, 1'b0, 8'hFF);
    settle();
    chk("a_oe", 32'h0000_0000, {24'h00_0000, pin_a_oe});
    bus(`TSGP_IDX_A_DIR, 1'b1, 1'b0, 8'hFF);
    settle();
    chk("a_oe", 32'h0000_00E8, {24'h00_0000, pin_a_oe});
    chk("a_out", 32'h0000_00E8, {24'h00_0000, pin_a_out});
    rd(`TSGP_IDX_A_DATA, 1'b0, 8'hE8);
    rd(`TSGP_IDX_A_DIR, 1'b0, 8'hE8);
    bus(`TSGP_IDX_B_DIR, 1'b1, 1'b0, 8'hFF);
    bus(`TSGP_IDX_B_DATA, 1'b1, 1'b0, 8'h02);
    settle();
    chk("b_oe_out", 32'h0000_0032, {24'h00_0000, 2'b00, pin_b_oe, 2'b00, pin_b_out});
  endtask : t_out
  // input pins read the pad, rmw reads the latch
  task automatic t_in;
    bus(`TSGP_IDX_A_DIR, 1'b1, 1'b0, 8'h00);
    bus(`TSGP_IDX_A_TDIS, 1'b1, 1'b0, 8'h1E);
    ext_val <= {8'h28, 2'b01};
    settle();
    rd(`TSGP_IDX_A_DATA, 1'b0, 8'h28);
    rd(`TSGP_IDX_A_DATA, 1'b1, 8'hE8);
  endtask : t_in
  // pull-up on every pin except the two driving low, a5 and b0
  task automatic t_pull;
    bus(`TSGP_IDX_A_PULL, 1'b1, 1'b0, 8'hFF);
    bus(`TSGP_IDX_A_DATA, 1'b1, 1'b0, 8'h08);
    bus(`TSGP_IDX_A_DIR, 1'b1, 1'b0, 8'h28);
    bus(`TSGP_IDX_B_PULL, 1'b1, 1'b0, 8'hFF);
    settle();
    chk("a_pull", 32'h0000_00C8, {24'h00_0000, pin_a_pull});
    chk("b_pull", 32'h0000_0002, {30'h0000_0000, pin_b_pull});
  endtask : t_pull
  // disable bits scattered: bit4 is the reference pin, bit1 channel one
  task automatic t_touch;
    bus(`TSGP_IDX_A_PULL, 1'b1, 1'b0, 8'h00);
    bus(`TSGP_IDX_A_DIR, 1'b1, 1'b0, 8'h00);
    bus(`TSGP_IDX_B_DIR, 1'b1, 1'b0, 8'h00);
    bus(`TSGP_IDX_B_PULL, 1'b1, 1'b0, 8'h00);
    bus(`TSGP_IDX_A_TDIS, 1'b1, 1'b0, 8'h10);
    settle();
    chk("touch_en", 32'h0000_001F, {26'h000_0000, touch_path_en});
    bus(`TSGP_IDX_A_TDIS, 1'b1, 1'b0, 8'h02);
    settle();
    chk("touch_en", 32'h0000_002F, {26'h000_0000, touch_path_en});
  endtask : t_touch
  // lock, lock with touch kept alive, plain standby and wake
  task automatic t_stby;
    bus(`TSGP_IDX_A_DIR, 1'b1, 1'b0, 8'h28);
    bus(`TSGP_IDX_A_PULL, 1'b1, 1'b0, 8'hFF);
    bus(`TSGP_IDX_STBY, 1'b1, 1'b0, 8'h01);
    ext_val <= {8'hC0, 2'b00};
    standby_req <= 1'b1;
    settle();
    chk("a_oe_lock", 32'h0000_0000, {16'h0000, pin_a_oe, pin_a_pull});
    rd(`TSGP_IDX_A_DATA, 1'b0, 8'h08);
    chk("touch_lock", 32'h0000_0000, {26'h000_0000, touch_path_en});
    bus(`TSGP_IDX_STBY, 1'b1, 1'b0, 8'h03);
    settle();
    chk("touch_stop", 32'h0000_002F, {26'h000_0000, touch_path_en});
    bus(`TSGP_IDX_STBY, 1'b1, 1'b0, 8'h0E);
    touch_irq <= 1'b1;
    settle();
    chk("a_oe_hold", 32'h0000_0028, {24'h00_0000, pin_a_oe});
    chk("wake_one", 32'h0000_0000, {31'h0000_0000, touch_wake});
    touch_gen_irq <= 1'b1;
    settle();
    chk("wake_both", 32'h0000_0001, {31'h0000_0000, touch_wake});
  endtask : t_stby
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_out();
    t_in();
    t_pull();
    t_touch();
    t_stby();
    give_verdict();
  end
  // watchdog: whole run is under two hundred cycles
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
endmodule : tb_top
